// ---- hw/ebmcc_pkg.sv ----
package ebmcc_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int BCLK_MIN_NS = 120;
    localparam int BCLK_MAX_NS = 250;
    localparam int BCLK_MIN_CYC = (BCLK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BCLK_MAX_CYC = BCLK_MAX_NS / CLK_PERIOD_NS;
    localparam int PERIOD_CNT_W = 6;
    localparam logic [1:0] REARM_BCLKS = 2'h2;
    localparam int DMA_CNT_W = 16;
    localparam logic [15:0] DMA_CNT_RESET = 16'h0000;

    // ****************************************
    // Synchronised pin vector positions
    // ****************************************
    localparam int SYNC_W = 7;
    localparam int PIN_BCLK = 0;
    localparam int PIN_GRANT_B = 1;
    localparam int PIN_READY_B = 2;
    localparam int PIN_WIDE_B = 3;
    localparam int PIN_HALF_B = 4;
    localparam int PIN_BURST_B = 5;
    localparam int PIN_BOARD_RESET = 6;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
        logic write;
        logic mem;
        logic burst;
    } ebmcc_req_t;

    typedef struct packed {
        logic wide;
        logic half;
        logic burst_ok;
    } ebmcc_width_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_REQ = 3'h1,
        ST_ADDR = 3'h3,
        ST_START = 3'h2,
        ST_CMD = 3'h6,
        ST_DONE = 3'h7,
        ST_HOLD = 3'h5
    } ebmcc_state_t;

    localparam ebmcc_req_t REQ_RESET = '0;
    localparam ebmcc_width_t WIDTH_RESET = '0;

endpackage

// ---- hw/ebmcc_sync.sv ----
`timescale 1ns/1ps

module ebmcc_sync
#(
    parameter int W = 1
)
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [W-1:0] pins_in,
    output logic [W-1:0] pins_out
);

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    // ****************************************
    // Three-stage capture
    // ****************************************
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end
        else
        begin
            stage1 <= pins_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A bit changes only once stages two and three agree
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            pins_out <= '0;
        end
        else
        begin
            for (int i = 0; i < W; i++)
            begin
                if (stage2[i] == stage3[i])
                begin
                    pins_out[i] <= stage3[i];
                end
            end
        end
    end

endmodule

// ---- hw/ebmcc_master.sv ----
`timescale 1ns/1ps

//Behaviour
//- Sampling board reset asserted resets all adapter logic except the synchroniser and bclk_q.
//- Low address lines 0-13 driven while the address latch enable is high.
//- Low address lines stay stable through every command phase, except where a burst cycle loads the next address.
//- Upper-byte enable asserted whenever a transfer uses data byte D8-D15.
//- Slave burst support sampled on rising bus clock edge to decide bursting.
//- Cycle start asserted only after latchable address and memory/IO select valid.
//- Cycle start released on the second rising edge, one and a half bus periods after assertion.
//- Terminal count pulse produced when DMA transfer count reaches terminal value.
//- Write/read select high for writes, low for reads.
//- Write/read valid after cycle start asserts and before command asserts.
//- Write/read held valid as long as latchable address stays valid.
//- Write/read launched from the same edge that asserts cycle start.
//- Cycle start launched on falling edge, command on rising edge.
//- Master request asserted and master grant sampled on falling edges.
//- Slave ready sampled on falling bus clock edge to end the cycle.
//- Slave wide and half acknowledges sampled on rising edge.
//- Memory/IO select high for memory, low for I/O, pipelined between cycles.
//- Master burst indication asserted with address on second and later burst cycles.
module ebmcc_master
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic bclk_in,
    input wire logic board_reset_line_in,
    input wire logic master_grant_b_in,
    input wire logic slave_ready_b_in,
    input wire logic slave_wide_ack_b_in,
    input wire logic slave_half_ack_b_in,
    input wire logic slave_burst_support_b_in,
    input wire logic [31:0] data_in,
    output logic master_request_b_out,
    output logic [31:2] latchable_address_lines_out,
    output logic [13:0] low_address_lines_out,
    output logic [3:0] byte_enables_b_out,
    output logic upper_byte_enable_b_out,
    output logic mem_io_out,
    output logic write_read_out,
    output logic start_b_out,
    output logic cmd_b_out,
    output logic master_burst_indication_b_out,
    output logic bus_oe_out,
    output logic [31:0] data_out,
    output logic data_oe_out,
    output logic terminal_count_pulse_out,
    input wire logic req_valid_in,
    input wire ebmcc_pkg::ebmcc_req_t req_in,
    output logic req_ready_out,
    output logic done_out,
    output logic [31:0] rdata_out,
    output ebmcc_pkg::ebmcc_width_t width_out,
    input wire logic dma_count_load_in,
    input wire logic [15:0] dma_count_in,
    output logic bclk_fault_out
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic uses_upper_lane(input logic [3:0] be);
        uses_upper_lane = be[1] | be[3];
    endfunction

    function automatic logic [1:0] low_byte_addr(input logic [3:0] be);
        if (be[0])
            low_byte_addr = 2'h0;
        else if (be[1])
            low_byte_addr = 2'h1;
        else if (be[2])
            low_byte_addr = 2'h2;
        else
            low_byte_addr = 2'h3;
    endfunction

    // ****************************************
    // Pin synchronisation and bus clock edges
    // ****************************************
    logic [ebmcc_pkg::SYNC_W-1:0] pins_s;
    logic bclk_q;
    logic rise_en;
    logic fall_en;
    logic core_rst;

    ebmcc_sync #(.W(ebmcc_pkg::SYNC_W)) u_sync
    (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .pins_in({board_reset_line_in, slave_burst_support_b_in, slave_half_ack_b_in,
                  slave_wide_ack_b_in, slave_ready_b_in, master_grant_b_in, bclk_in}),
        .pins_out(pins_s)
    );

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            bclk_q <= 1'b0;
        end
        else
        begin
            bclk_q <= pins_s[ebmcc_pkg::PIN_BCLK];
        end
    end

    assign rise_en = pins_s[ebmcc_pkg::PIN_BCLK] & ~bclk_q;
    assign fall_en = ~pins_s[ebmcc_pkg::PIN_BCLK] & bclk_q;
    // Board reset sampled asserted clears everything but the synchroniser and bclk_q
    assign core_rst = ~rst_b_in | pins_s[ebmcc_pkg::PIN_BOARD_RESET];

    // ****************************************
    // Bus clock period check
    // ****************************************
    logic [ebmcc_pkg::PERIOD_CNT_W-1:0] period_cnt;

    always_ff @(posedge clk_in)
    begin
        if (core_rst)
        begin
            period_cnt <= '0;
            bclk_fault_out <= 1'b0;
        end
        else if (rise_en)
        begin
            period_cnt <= '0;
            bclk_fault_out <= (period_cnt < ebmcc_pkg::PERIOD_CNT_W'(ebmcc_pkg::BCLK_MIN_CYC - 1)) ||
                              (period_cnt > ebmcc_pkg::PERIOD_CNT_W'(ebmcc_pkg::BCLK_MAX_CYC));
        end
        else if (period_cnt > ebmcc_pkg::PERIOD_CNT_W'(ebmcc_pkg::BCLK_MAX_CYC))
        begin
            bclk_fault_out <= 1'b1;
        end
        else
        begin
            period_cnt <= period_cnt + 1'b1;
        end
    end

    // ****************************************
    // Cycle state machine
    // ****************************************
    ebmcc_pkg::ebmcc_state_t state;
    ebmcc_pkg::ebmcc_req_t cur;
    logic start_half;
    logic [1:0] rearm_cnt;
    logic ready_s;
    logic burst_go;
    logic take_new;
    logic take_burst;

    assign ready_s = ~pins_s[ebmcc_pkg::PIN_READY_B];
    assign burst_go = width_out.burst_ok & cur.burst & req_valid_in & req_in.burst & req_in.write == cur.write
                      & req_in.mem == cur.mem;
    assign take_new = (state == ebmcc_pkg::ST_IDLE) & fall_en;
    assign take_burst = (state == ebmcc_pkg::ST_CMD) & fall_en & ready_s & burst_go;
    assign req_ready_out = (take_new | take_burst) & ~core_rst;

    always_ff @(posedge clk_in)
    begin
        if (core_rst)
        begin
            state <= ebmcc_pkg::ST_IDLE;
            start_half <= 1'b0;
            rearm_cnt <= '0;
        end
        else
        begin
            unique case (state)
                ebmcc_pkg::ST_IDLE:
                begin
                    if (take_new && req_valid_in)
                    begin
                        state <= ebmcc_pkg::ST_REQ;
                    end
                end
                ebmcc_pkg::ST_REQ:
                begin
                    if (fall_en && !pins_s[ebmcc_pkg::PIN_GRANT_B])
                    begin
                        state <= ebmcc_pkg::ST_ADDR;
                    end
                end
                ebmcc_pkg::ST_ADDR:
                begin
                    if (fall_en)
                    begin
                        state <= ebmcc_pkg::ST_START;
                        start_half <= 1'b0;
                    end
                end
                ebmcc_pkg::ST_START:
                begin
                    if (rise_en)
                    begin
                        start_half <= 1'b1;
                        if (start_half)
                        begin
                            state <= ebmcc_pkg::ST_CMD;
                        end
                    end
                end
                ebmcc_pkg::ST_CMD:
                begin
                    if (fall_en && ready_s && !take_burst)
                    begin
                        state <= ebmcc_pkg::ST_DONE;
                    end
                end
                ebmcc_pkg::ST_DONE:
                begin
                    if (rise_en)
                    begin
                        state <= ebmcc_pkg::ST_HOLD;
                        rearm_cnt <= ebmcc_pkg::REARM_BCLKS;
                    end
                end
                ebmcc_pkg::ST_HOLD:
                begin
                    if (rise_en)
                    begin
                        rearm_cnt <= rearm_cnt - 1'b1;
                        if (rearm_cnt == 2'h1)
                        begin
                            state <= ebmcc_pkg::ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    state <= ebmcc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Captured request
    // ****************************************
    always_ff @(posedge clk_in)
    begin
        if (core_rst)
        begin
            cur <= ebmcc_pkg::REQ_RESET;
        end
        else if (req_valid_in && req_ready_out)
        begin
            cur <= req_in;
        end
    end

    // ****************************************
    // Arbitration pins
    // ****************************************
    always_ff @(posedge clk_in)
    begin
        if (core_rst)
        begin
            master_request_b_out <= 1'b1;
        end
        else if (take_new && req_valid_in)
        begin
            master_request_b_out <= 1'b0;
        end
        else if (state == ebmcc_pkg::ST_DONE && rise_en)
        begin
            master_request_b_out <= 1'b1;
        end
    end

    // ****************************************
    // Address and status group
    // ****************************************
    always_ff @(posedge clk_in)
    begin
        if (core_rst)
        begin
            bus_oe_out <= 1'b0;
            latchable_address_lines_out <= '0;
            low_address_lines_out <= '0;
            mem_io_out <= 1'b0;
            master_burst_indication_b_out <= 1'b1;
        end
        else if (state == ebmcc_pkg::ST_REQ && fall_en && !pins_s[ebmcc_pkg::PIN_GRANT_B])
        begin
            // Address, low address and memory/IO go out together and hold until a burst cycle loads the next address
            bus_oe_out <= 1'b1;
            latchable_address_lines_out <= cur.addr[31:2];
            low_address_lines_out <= {cur.addr[13:2], low_byte_addr(cur.be)};
            mem_io_out <= cur.mem;
            master_burst_indication_b_out <= 1'b1;
        end
        else if (take_burst && req_valid_in)
        begin
            latchable_address_lines_out <= req_in.addr[31:2];
            low_address_lines_out <= {req_in.addr[13:2], low_byte_addr(req_in.be)};
            mem_io_out <= req_in.mem;
            master_burst_indication_b_out <= 1'b0;
        end
        else if (state == ebmcc_pkg::ST_DONE && rise_en)
        begin
            bus_oe_out <= 1'b0;
            master_burst_indication_b_out <= 1'b1;
        end
    end

    // ****************************************
    // Start, command, write/read and byte enables
    // ****************************************
    always_ff @(posedge clk_in)
    begin
        if (core_rst)
        begin
            start_b_out <= 1'b1;
            cmd_b_out <= 1'b1;
            write_read_out <= 1'b0;
            byte_enables_b_out <= 4'hF;
            upper_byte_enable_b_out <= 1'b1;
        end
        else if (state == ebmcc_pkg::ST_ADDR && fall_en)
        begin
            // Status follows start from the same falling edge
            start_b_out <= 1'b0;
            write_read_out <= cur.write;
            byte_enables_b_out <= ~cur.be;
            upper_byte_enable_b_out <= ~uses_upper_lane(cur.be);
        end
        else if (state == ebmcc_pkg::ST_START && rise_en && start_half)
        begin
            start_b_out <= 1'b1;
            cmd_b_out <= 1'b0;
        end
        else if (take_burst && req_valid_in)
        begin
            byte_enables_b_out <= ~req_in.be;
            upper_byte_enable_b_out <= ~uses_upper_lane(req_in.be);
        end
        else if (state == ebmcc_pkg::ST_DONE && rise_en)
        begin
            // Command and byte enables are released together with the address group
            cmd_b_out <= 1'b1;
            byte_enables_b_out <= 4'hF;
            upper_byte_enable_b_out <= 1'b1;
        end
    end

    // ****************************************
    // Slave acknowledges
    // ****************************************
    always_ff @(posedge clk_in)
    begin
        if (core_rst)
        begin
            width_out <= ebmcc_pkg::WIDTH_RESET;
        end
        else if (rise_en && (state == ebmcc_pkg::ST_CMD || (state == ebmcc_pkg::ST_START && start_half)))
        begin
            width_out.wide <= ~pins_s[ebmcc_pkg::PIN_WIDE_B];
            width_out.half <= ~pins_s[ebmcc_pkg::PIN_HALF_B];
            width_out.burst_ok <= ~pins_s[ebmcc_pkg::PIN_BURST_B];
        end
    end

    // ****************************************
    // Data path
    // ****************************************
    always_ff @(posedge clk_in)
    begin
        if (core_rst)
        begin
            data_out <= '0;
            data_oe_out <= 1'b0;
        end
        else if (state == ebmcc_pkg::ST_ADDR && fall_en)
        begin
            data_out <= cur.wdata;
            data_oe_out <= cur.write;
        end
        else if (take_burst && req_valid_in)
        begin
            data_out <= req_in.wdata;
        end
        else if (state == ebmcc_pkg::ST_DONE && rise_en)
        begin
            data_oe_out <= 1'b0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (core_rst)
        begin
            rdata_out <= '0;
            done_out <= 1'b0;
        end
        else
        begin
            done_out <= (state == ebmcc_pkg::ST_CMD) && fall_en && ready_s;
            if ((state == ebmcc_pkg::ST_CMD) && fall_en && ready_s && !cur.write)
            begin
                rdata_out <= data_in;
            end
        end
    end

    // ****************************************
    // DMA transfer count and terminal count
    // ****************************************
    logic [ebmcc_pkg::DMA_CNT_W-1:0] dma_cnt;

    always_ff @(posedge clk_in)
    begin
        if (core_rst)
        begin
            dma_cnt <= ebmcc_pkg::DMA_CNT_RESET;
            terminal_count_pulse_out <= 1'b0;
        end
        else
        begin
            if (dma_count_load_in)
            begin
                dma_cnt <= dma_count_in;
            end
            else if (done_out && dma_cnt != '0)
            begin
                dma_cnt <= dma_cnt - 1'b1;
            end
            // Pulse lasts from the terminal transfer to the next rising bus edge
            if (done_out && dma_cnt == 16'h0001 && !dma_count_load_in)
            begin
                terminal_count_pulse_out <= 1'b1;
            end
            else if (rise_en)
            begin
                terminal_count_pulse_out <= 1'b0;
            end
        end
    end

endmodule

// ---- test/ebmcc_board_model.sv ----
`timescale 1ns/1ps

module ebmcc_board_model
#(
    parameter logic [31:0] RD_VALUE = 32'h0000_0000
)
(
    input wire logic master_request_b_in,
    input wire logic start_b_in,
    input wire logic cmd_b_in,
    input wire logic write_read_in,
    input wire logic mem_io_in,
    input wire logic [31:2] latchable_address_lines_in,
    input wire logic [3:0] waits_in,
    input wire logic wide_in,
    input wire logic half_in,
    input wire logic burst_in,
    output logic bclk_out,
    output logic master_grant_b_out,
    output logic slave_ready_b_out,
    output logic slave_wide_ack_b_out,
    output logic slave_half_ack_b_out,
    output logic slave_burst_support_b_out,
    output logic [31:0] rd_data_out
);
    // ****************************************
    // Arbiter and slave
    // ****************************************
    logic active;
    logic [3:0] cnt;

    assign active = !start_b_in || !cmd_b_in;
    assign slave_wide_ack_b_out = !(wide_in && active);
    assign slave_half_ack_b_out = !(half_in && active);
    assign slave_burst_support_b_out = !(burst_in && mem_io_in && latchable_address_lines_in[31:10] == 22'h0 && active);
    // Inverse unless reading
    assign rd_data_out = (!cmd_b_in && !write_read_in) ? RD_VALUE : ~RD_VALUE;

    initial
    begin
        bclk_out = 1'h0;
        master_grant_b_out = 1'h1;
        slave_ready_b_out = 1'h0;
        cnt = 4'h0;
        forever #80 bclk_out = ~bclk_out;
    end

    always @(posedge bclk_out)
    begin
        master_grant_b_out <= master_request_b_in;
        if (active && cnt < waits_in)
        begin
            cnt <= cnt + 4'h1;
            slave_ready_b_out <= 1'h1;
        end
        else
        begin
            cnt <= 4'h0;
            slave_ready_b_out <= 1'h0;
        end
    end
endmodule

// ---- test/ebmcc_props.sv ----
`timescale 1ns/1ps

module ebmcc_props
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic board_reset_line_in,
    input wire logic master_grant_b_in,
    input wire logic slave_ready_b_in,
    input wire logic master_request_b_out,
    input wire logic [31:2] latchable_address_lines_out,
    input wire logic [13:0] low_address_lines_out,
    input wire logic [3:0] byte_enables_b_out,
    input wire logic upper_byte_enable_b_out,
    input wire logic mem_io_out,
    input wire logic write_read_out,
    input wire logic start_b_out,
    input wire logic cmd_b_out,
    input wire logic master_burst_indication_b_out,
    input wire logic bus_oe_out,
    input wire logic data_oe_out,
    input wire logic terminal_count_pulse_out,
    input wire logic done_out
);
    // ****************************************
    // Bus cycle properties
    // ****************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    sequence s_cmd_held;
        !cmd_b_out ##1 !cmd_b_out;
    endsequence

    sequence s_board_rst;
        board_reset_line_in [*7];
    endsequence

    start_end_a: assert property ($rose(start_b_out) && !board_reset_line_in |-> $fell(cmd_b_out))
        else $error("start end without command");
    addr_first_a: assert property ($fell(start_b_out) |-> bus_oe_out && $stable(latchable_address_lines_out))
        else $error("start before address");
    wr_held_a: assert property (s_cmd_held |-> $stable(write_read_out) && $stable(mem_io_out))
        else $error("status moved");
    wr_early_a: assert property ($fell(cmd_b_out) |-> $stable(write_read_out) && $past(!start_b_out))
        else $error("write read late");
    low_addr_a: assert property (s_cmd_held ##0 ($past(master_burst_indication_b_out) && master_burst_indication_b_out)
        |-> $stable(low_address_lines_out))
        else $error("low address moved");
    upper_lane_a: assert property (!cmd_b_out |-> upper_byte_enable_b_out == (byte_enables_b_out[1] & byte_enables_b_out[3]))
        else $error("upper enable wrong");
    wdata_dir_a: assert property (data_oe_out |-> write_read_out && bus_oe_out)
        else $error("data driven on read");
    ready_wait_a: assert property (slave_ready_b_in [*8] |=> !done_out)
        else $error("done while slave waits");
    owned_a: assert property ($rose(bus_oe_out) |-> !master_request_b_out && !master_grant_b_in)
        else $error("no grant");
    tc_done_a: assert property ($rose(terminal_count_pulse_out) |-> done_out || $past(done_out))
        else $error("stray terminal count");
    brst_idle_a: assert property (s_board_rst |-> master_request_b_out && start_b_out && cmd_b_out && !bus_oe_out)
        else $error("board reset ignored");
endmodule

bind ebmcc_master ebmcc_props i_props (.*);

// ---- test/tb.sv ----
`timescale 1ns/1ps

module tb;
    localparam logic [31:0] RD_VALUE = 32'hA5C3_1E0F;
    logic clk_in, rst_b_in, bclk_in, board_reset_line_in, master_grant_b_in, slave_ready_b_in;
    logic slave_wide_ack_b_in, slave_half_ack_b_in, slave_burst_support_b_in, req_valid_in, dma_count_load_in;
    logic [31:0] data_in, data_out, rdata_out;
    logic [15:0] dma_count_in;
    logic [31:2] latchable_address_lines_out;
    logic [13:0] low_address_lines_out;
    logic [3:0] byte_enables_b_out, waits;
    logic master_request_b_out, upper_byte_enable_b_out, mem_io_out, write_read_out, start_b_out, cmd_b_out;
    logic master_burst_indication_b_out, bus_oe_out, data_oe_out, terminal_count_pulse_out, req_ready_out;
    logic done_out, bclk_fault_out, wide_mode, half_mode, burst_mode, tc_seen, burst_seen;
    ebmcc_pkg::ebmcc_req_t req_in;
    ebmcc_pkg::ebmcc_width_t width_out;
    int n_fail, compares, i;

    ebmcc_master i_dut (.*);

    ebmcc_board_model #(.RD_VALUE(RD_VALUE)) i_board
    (
        .master_request_b_in(master_request_b_out), .start_b_in(start_b_out), .cmd_b_in(cmd_b_out),
        .write_read_in(write_read_out), .mem_io_in(mem_io_out), .latchable_address_lines_in(latchable_address_lines_out),
        .waits_in(waits), .wide_in(wide_mode), .half_in(half_mode), .burst_in(burst_mode), .bclk_out(bclk_in),
        .master_grant_b_out(master_grant_b_in), .slave_ready_b_out(slave_ready_b_in),
        .slave_wide_ack_b_out(slave_wide_ack_b_in), .slave_half_ack_b_out(slave_half_ack_b_in),
        .slave_burst_support_b_out(slave_burst_support_b_in), .rd_data_out(data_in)
    );

    // ****************************************
    // Helpers
    // ****************************************
    initial forever #5 clk_in = ~clk_in;

    always @(posedge clk_in)
    begin
        if (terminal_count_pulse_out === 1'h1)
            tc_seen <= 1'h1;
        if (master_burst_indication_b_out === 1'h0)
            burst_seen <= 1'h1;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic report_and_stop;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic tmo;
        if (i >= 900)
        begin
            n_fail++;
            report_and_stop();
        end
    endtask

    task automatic issue(input logic [31:0] a, input logic [3:0] be, input logic w, input logic m, input logic b);
        @(negedge clk_in);
        req_in = '{a, be, ~a, w, m, b};
        req_valid_in = 1'h1;
        #1;
        for (i = 0; i < 900 && req_ready_out !== 1'h1; i++) @(negedge clk_in);
        tmo();
    endtask

    task automatic wait_cmd(input logic lvl);
        for (i = 0; i < 900 && cmd_b_out !== lvl; i++) @(negedge clk_in);
        tmo();
    endtask

    task automatic xfer(input logic [31:0] a, input logic [3:0] be, input logic w, input logic m);
        issue(a, be, w, m, 1'h0);
        @(negedge clk_in);
        req_valid_in = 1'h0;
        wait_cmd(1'h0);
        chk("write_read", w, write_read_out);
        chk("mem_io", m, mem_io_out);
        chk("byte_en", be, 4'hF ^ byte_enables_b_out);
        chk("upper_en", !(be[1] | be[3]), upper_byte_enable_b_out);
        chk("address", a[31:2], latchable_address_lines_out);
        chk("low_addr", {a[13:2], be[0] ? 2'h0 : be[1] ? 2'h1 : be[2] ? 2'h2 : 2'h3}, low_address_lines_out);
        if (w) chk("wdata", ~a, data_out);
        for (i = 0; i < 900 && done_out !== 1'h1; i++) @(negedge clk_in);
        tmo();
        chk("wide", wide_mode, width_out.wide);
        chk("half", half_mode, width_out.half);
        if (!w) chk("rdata", RD_VALUE, rdata_out);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic sc_plain;
        wide_mode = 1'h1;
        xfer(32'h0000_1234, 4'hF, 1'h1, 1'h1);
        xfer(32'h0000_2008, 4'hC, 1'h0, 1'h1);
    endtask

    task automatic sc_wait_io;
        waits = 4'h3;
        wide_mode = 1'h0;
        half_mode = 1'h1;
        xfer(32'h0000_0300, 4'h2, 1'h0, 1'h0);
        xfer(32'h0000_0304, 4'h8, 1'h1, 1'h0);
    endtask

    task automatic sc_burst;
        waits = 4'h1;
        burst_mode = 1'h1;
        burst_seen = 1'h0;
        issue(32'h0000_0100, 4'hF, 1'h1, 1'h1, 1'h1);
        issue(32'h0000_0104, 4'hF, 1'h1, 1'h1, 1'h1);
        @(negedge clk_in);
        req_valid_in = 1'h0;
        wait_cmd(1'h1);
        chk("burst_seen", 1'h1, burst_seen);
        burst_mode = 1'h0;
    endtask

    task automatic sc_tc;
        @(negedge clk_in);
        dma_count_in = 16'h0002;
        dma_count_load_in = 1'h1;
        @(negedge clk_in);
        dma_count_load_in = 1'h0;
        tc_seen = 1'h0;
        xfer(32'h0000_0040, 4'h1, 1'h1, 1'h1);
        chk("tc_early", 1'h0, tc_seen);
        xfer(32'h0000_0044, 4'h1, 1'h1, 1'h1);
        repeat (4) @(negedge clk_in);
        chk("tc_last", 1'h1, tc_seen);
    endtask

    task automatic sc_board_reset;
        waits = 4'h6;
        issue(32'h0000_0800, 4'hF, 1'h0, 1'h1, 1'h0);
        @(negedge clk_in);
        req_valid_in = 1'h0;
        wait_cmd(1'h0);
        board_reset_line_in = 1'h1;
        repeat (160) @(negedge clk_in);
        chk("start_b", 1'h1, start_b_out);
        chk("cmd_b", 1'h1, cmd_b_out);
        chk("request_b", 1'h1, master_request_b_out);
        chk("bus_oe", 1'h0, bus_oe_out);
        board_reset_line_in = 1'h0;
        waits = 4'h0;
        xfer(32'h0000_0C00, 4'h3, 1'h1, 1'h1);
    endtask

    initial
    begin
        clk_in = 1'h0;
        rst_b_in = 1'h0;
        board_reset_line_in = 1'h0;
        req_valid_in = 1'h0;
        req_in = '0;
        dma_count_load_in = 1'h0;
        dma_count_in = 16'h0000;
        waits = 4'h0;
        wide_mode = 1'h0;
        half_mode = 1'h0;
        burst_mode = 1'h0;
        n_fail = 0;
        compares = 0;
        repeat (8) @(posedge clk_in);
        @(negedge clk_in);
        rst_b_in = 1'h1;
        sc_plain();
        sc_wait_io();
        sc_burst();
        sc_tc();
        sc_board_reset();
        chk("bclk_fault", 1'h0, bclk_fault_out);
        report_and_stop();
    end
endmodule
